//--- hdl/hidden_register_loader_poll_config.sv
`timescale 1ns/1ps
module hidden_register_loader_poll_config (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic pon,
  input wire logic chip_reset_cmd,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic remote_cfg_mode,
  input wire logic ist,
  input wire logic ppc_rcv,
  input wire logic ppe_rcv,
  input wire logic ppd_rcv,
  input wire logic other_pcg_rcv,
  input wire logic [3:0] ppe_data,
  input wire logic idy_pin,
  input wire logic xfer_start,
  input wire logic xfer_cmd,
  input wire logic fast_timing,
  output logic settle_busy,
  output logic settle_done,
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe
);
  logic [3:0] div_q, div_d;
  logic [4:0] cfg_q, cfg_d;
  logic [4:0] rem_q, rem_d;
  hidden_reg_pkg::pacs_e pacs_q, pacs_d;
  logic [7:0] rdata_q;
  logic [7:0] oe_q, oe_d;
  logic [7:0] out_q;
  logic busy_q, done_q;
  logic pon_m_q, pon_s_q, idy_m_q, idy_s_q;
  logic clr;
  logic aux_wr;
  logic [2:0] sel;
  logic [4:0] eff_cfg;

  delay_ctl_if tif ();

  settle_timer u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .ctl(tif.tmr)
  );

  assign tif.divisor = div_q;
  assign tif.start = xfer_start;
  assign tif.cmd_xfer = xfer_cmd;
  assign tif.fast = fast_timing;

  // The pon and idy_pin inputs pass two flops
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pon_m_q <= 1'b0;
      pon_s_q <= 1'b0;
      idy_m_q <= 1'b0;
      idy_s_q <= 1'b0;
    end
    else
    begin
      pon_m_q <= pon;
      pon_s_q <= pon_m_q;
      idy_m_q <= idy_pin;
      idy_s_q <= idy_m_q;
    end
  end

  always_comb
  begin
    clr = chip_reset_cmd || pon_s_q;
    sel = host_wdata[hidden_reg_pkg::SEL_MSB:hidden_reg_pkg::SEL_LSB];
    aux_wr = host_wr && (host_addr == hidden_reg_pkg::AUX_MODE_OFS);
  end

  // Hidden register loading
  always_comb
  begin
    div_d = div_q;
    cfg_d = cfg_q;
    if (clr)
    begin
      div_d = hidden_reg_pkg::DIV_RESET;
      cfg_d = hidden_reg_pkg::CFG_RESET;
    end
    else if (aux_wr)
    begin
      case (sel)
        hidden_reg_pkg::SEL_COUNTER_DIV:
          div_d = host_wdata[3:0];
        hidden_reg_pkg::SEL_POLL_CFG:
          cfg_d = host_wdata[hidden_reg_pkg::DATA_MSB:0];
        default:
          cfg_d = cfg_q;
      endcase
    end
  end

  // Remote configuration: PPC arms, PPE/PPD then load or unconfigure
  always_comb
  begin
    pacs_d = pacs_q;
    rem_d = rem_q;
    if (clr)
    begin
      pacs_d = hidden_reg_pkg::PACS_IDLE;
      rem_d = hidden_reg_pkg::CFG_RESET;
    end
    else
    begin
      case (pacs_q)
        hidden_reg_pkg::PACS_IDLE:
          if (ppc_rcv)
            pacs_d = hidden_reg_pkg::PACS_ARMED;
        hidden_reg_pkg::PACS_ARMED:
        begin
          if (ppe_rcv)
            rem_d = {1'b0, ppe_data};
          else if (ppd_rcv)
            rem_d = hidden_reg_pkg::CFG_RESET;
          if (other_pcg_rcv)
            pacs_d = hidden_reg_pkg::PACS_IDLE;
        end
        default:
          pacs_d = hidden_reg_pkg::PACS_IDLE;
      endcase
    end
  end

  // Poll response on the selected line, open collector
  always_comb
  begin
    eff_cfg = remote_cfg_mode ? rem_q : cfg_q;
    oe_d = 8'h00;
    if (idy_s_q && !eff_cfg[hidden_reg_pkg::CFG_UNCONF_BIT]
        && (eff_cfg[hidden_reg_pkg::CFG_SENSE_BIT] == ist))
      oe_d[eff_cfg[hidden_reg_pkg::CFG_LINE_MSB:0]] = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      div_q <= hidden_reg_pkg::DIV_RESET;
      cfg_q <= hidden_reg_pkg::CFG_RESET;
      rem_q <= hidden_reg_pkg::CFG_RESET;
      pacs_q <= hidden_reg_pkg::PACS_IDLE;
      rdata_q <= hidden_reg_pkg::READ_ZERO;
      oe_q <= 8'h00;
      out_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      cfg_q <= cfg_d;
      rem_q <= rem_d;
      pacs_q <= pacs_d;
      rdata_q <= hidden_reg_pkg::READ_ZERO;
      oe_q <= oe_d;
      out_q <= 8'h00;
      busy_q <= tif.busy;
      done_q <= tif.done;
    end
  end

  assign host_rdata = rdata_q;
  assign dio_oe = oe_q;
  assign dio_out = out_q;
  assign settle_busy = busy_q;
  assign settle_done = done_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_LOAD_DIV: assert property (aux_wr && !clr && sel == hidden_reg_pkg::SEL_COUNTER_DIV
    |=> div_q == $past(host_wdata[3:0]))
    else $error("divisor not loaded from select 001 write");
  AST_LOAD_CFG: assert property (aux_wr && !clr && sel == hidden_reg_pkg::SEL_POLL_CFG
    |=> cfg_q == $past(host_wdata[4:0]))
    else $error("poll configuration not loaded from select 011 write");
  AST_OTHER_SEL: assert property (aux_wr && !clr && sel != hidden_reg_pkg::SEL_COUNTER_DIV
    && sel != hidden_reg_pkg::SEL_POLL_CFG |=> $stable(div_q) && $stable(cfg_q))
    else $error("other select code changed a register");
  AST_HOLD: assert property (!aux_wr && !clr |=> $stable(div_q) && $stable(cfg_q))
    else $error("hidden register changed without write or reset");
  AST_CLEAR: assert property (clr
    |=> div_q == hidden_reg_pkg::DIV_RESET && cfg_q == hidden_reg_pkg::CFG_RESET)
    else $error("reset command did not restore hidden registers");
  AST_NO_READ: assert property (host_rd |=> host_rdata == 8'h00)
    else $error("hidden register read returned data");
  AST_UNCONF: assert property (eff_cfg[4] |=> dio_oe == 8'h00)
    else $error("unconfigured device drove a poll line");
  AST_RESPOND: assert property (idy_s_q && !eff_cfg[4] && eff_cfg[3] == ist
    |=> dio_oe == (8'h01 << $past(eff_cfg[2:0])))
    else $error("configured poll response on wrong line");
  AST_OPEN_COLL: assert property (dio_oe != 8'h00 |-> dio_out == 8'h00)
    else $error("poll line driven high");
  AST_REMOTE_PPE: assert property (pacs_q == hidden_reg_pkg::PACS_ARMED && ppe_rcv
    && !clr |=> rem_q == {1'b0, $past(ppe_data)})
    else $error("remote PPE not applied");
endmodule : hidden_register_loader_poll_config

//--- hdl/hidden_reg_pkg.sv
package hidden_reg_pkg;
  // Register port and hidden register select codes
  localparam logic [2:0] AUX_MODE_OFS = 3'h5;
  localparam logic [2:0] SEL_COUNTER_DIV = 3'h1;
  localparam logic [2:0] SEL_POLL_CFG = 3'h3;
  // Field layout of the auxiliary mode register
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int DATA_MSB = 4;
  // Field layout of the poll configuration
  localparam int CFG_UNCONF_BIT = 4;
  localparam int CFG_SENSE_BIT = 3;
  localparam int CFG_LINE_MSB = 2;
  // Reset values
  localparam logic [3:0] DIV_RESET = 4'h5;
  localparam logic [4:0] CFG_RESET = 5'h10;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Settling delay in prescaled ticks
  localparam logic [3:0] SETTLE_DATA_TICKS = 4'h4;
  localparam logic [3:0] SETTLE_FAST_TICKS = 4'h1;
  localparam logic [3:0] SETTLE_CMD_TICKS = 4'h4;

  typedef enum logic [0:0] {
    PACS_IDLE = 1'b0,
    PACS_ARMED = 1'b1
  } pacs_e;

  typedef enum logic [0:0] {
    TMR_IDLE = 1'b0,
    TMR_RUN = 1'b1
  } tmr_e;
endpackage : hidden_reg_pkg

//--- hdl/delay_ctl_if.sv
`timescale 1ns/1ps
interface delay_ctl_if;
  logic [3:0] divisor;
  logic start;
  logic cmd_xfer;
  logic fast;
  logic busy;
  logic done;
  modport ctl (output divisor, output start, output cmd_xfer, output fast,
    input busy, input done);
  modport tmr (input divisor, input start, input cmd_xfer, input fast,
    output busy, output done);
endinterface : delay_ctl_if

//--- hdl/settle_timer.sv
`timescale 1ns/1ps
module settle_timer (
  input wire logic clk_sys,
  input wire logic srst,
  delay_ctl_if.tmr ctl
);
  hidden_reg_pkg::tmr_e state_q, state_d;
  logic [3:0] pre_q, pre_d;
  logic [3:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic tick;
  logic [3:0] pre_last;

  // Divisor of zero means a tick every cycle
  always_comb
  begin
    pre_last = (ctl.divisor == 4'h0) ? 4'h0 : ctl.divisor - 4'h1;
    tick = (pre_q == pre_last);
  end

  always_comb
  begin
    state_d = state_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (state_q)
      hidden_reg_pkg::TMR_IDLE:
      begin
        pre_d = 4'h0;
        if (ctl.start)
        begin
          state_d = hidden_reg_pkg::TMR_RUN;
          if (ctl.cmd_xfer)
            cnt_d = hidden_reg_pkg::SETTLE_CMD_TICKS;
          else if (ctl.fast)
            cnt_d = hidden_reg_pkg::SETTLE_FAST_TICKS;
          else
            cnt_d = hidden_reg_pkg::SETTLE_DATA_TICKS;
        end
      end
      hidden_reg_pkg::TMR_RUN:
      begin
        pre_d = tick ? 4'h0 : pre_q + 4'h1;
        if (tick)
        begin
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            state_d = hidden_reg_pkg::TMR_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default:
        state_d = hidden_reg_pkg::TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= hidden_reg_pkg::TMR_IDLE;
      pre_q <= 4'h0;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign ctl.busy = (state_q == hidden_reg_pkg::TMR_RUN);
  assign ctl.done = done_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_start_data;
    !ctl.busy && ctl.start && !ctl.cmd_xfer && !ctl.fast && ctl.divisor == 4'h0;
  endsequence
  sequence s_done_after_four;
    !ctl.done [*4] ##1 ctl.done;
  endsequence

  AST_SETTLE_DATA: assert property (s_start_data |=> s_done_after_four)
    else $error("data settling delay not four ticks");
  AST_PRESCALE: assert property (ctl.busy && ctl.divisor == 4'h3 && pre_q == 4'h0
    |=> pre_q == 4'h1 ##1 pre_q == 4'h2 ##1 pre_q == 4'h0)
    else $error("prescaler does not divide by divisor");
endmodule : settle_timer

//--- verif/poll_controller_model.sv
`timescale 1ns/1ps
module poll_controller_model (
  input wire logic clk_sys,
  input wire logic [7:0] dio_oe,
  input wire logic [7:0] dio_out,
  output logic idy_pin,
  output logic ppc_rcv,
  output logic ppe_rcv,
  output logic ppd_rcv,
  output logic other_pcg_rcv,
  output logic [3:0] ppe_data,
  output wire logic [7:0] dio_bus
);
  // Open-collector wire with pull-up
  for (genvar i = 0; i < 8; i++)
  begin : g_wire
    assign dio_bus[i] = dio_oe[i] ? dio_out[i] : 1'b1;
  end

  initial
  begin
    idy_pin = 1'b0;
    {ppc_rcv, ppe_rcv, ppd_rcv, other_pcg_rcv} = 4'h0;
    ppe_data = 4'h0;
  end

  // One-hot msg: ppc, ppe, ppd, other
  task automatic send(input logic [3:0] msg, input logic [3:0] d);
    @(posedge clk_sys);
    #1;
    ppe_data = d;
    {ppc_rcv, ppe_rcv, ppd_rcv, other_pcg_rcv} = msg;
    @(posedge clk_sys);
    #1;
    {ppc_rcv, ppe_rcv, ppd_rcv, other_pcg_rcv} = 4'h0;
    ppe_data = ~d;
  endtask : send

  // Asserted lines read back as ones
  task automatic poll(output logic [7:0] resp);
    @(posedge clk_sys);
    #1;
    idy_pin = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    resp = ~dio_bus;
    idy_pin = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : poll
endmodule : poll_controller_model

//--- verif/hidden_register_loader_poll_config_test.sv
`timescale 1ns/1ps
module hidden_register_loader_poll_config_test;
  typedef struct packed
  {
    logic [7:0] wdata;
    logic ist;
    logic [7:0] oe;
  } row_s;
  logic clk_sys = 1'b0, srst = 1'b1, pon = 1'b0, chip_reset_cmd = 1'b0;
  logic host_wr = 1'b0, host_rd = 1'b0, remote_cfg_mode = 1'b0, ist = 1'b0;
  logic xfer_start = 1'b0, xfer_cmd = 1'b0, fast_timing = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata, dio_out, dio_oe, dio_bus, got;
  logic settle_busy, settle_done, idy_pin, ppc_rcv, ppe_rcv, ppd_rcv, other_pcg_rcv;
  logic [3:0] ppe_data;
  int fails = 0, cmp_count = 0, n;
  row_s rows [8] = '{'{8'h69, 1'b1, 8'h02}, '{8'h69, 1'b0, 8'h00}, '{8'h60, 1'b0, 8'h01},
    '{8'h60, 1'b1, 8'h00}, '{8'h6F, 1'b1, 8'h80}, '{8'h29, 1'b1, 8'h80},
    '{8'h89, 1'b1, 8'h80}, '{8'h70, 1'b1, 8'h00}};

  always #20 clk_sys = ~clk_sys;

  hidden_register_loader_poll_config uut (.clk_sys(clk_sys), .srst(srst), .pon(pon),
    .chip_reset_cmd(chip_reset_cmd), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .remote_cfg_mode(remote_cfg_mode), .ist(ist), .ppc_rcv(ppc_rcv), .ppe_rcv(ppe_rcv),
    .ppd_rcv(ppd_rcv), .other_pcg_rcv(other_pcg_rcv), .ppe_data(ppe_data),
    .idy_pin(idy_pin), .xfer_start(xfer_start), .xfer_cmd(xfer_cmd),
    .fast_timing(fast_timing), .settle_busy(settle_busy), .settle_done(settle_done),
    .dio_in(dio_bus), .dio_out(dio_out), .dio_oe(dio_oe));

  poll_controller_model pc (.clk_sys(clk_sys), .dio_oe(dio_oe), .dio_out(dio_out),
    .idy_pin(idy_pin), .ppc_rcv(ppc_rcv), .ppe_rcv(ppe_rcv), .ppd_rcv(ppd_rcv),
    .other_pcg_rcv(other_pcg_rcv), .ppe_data(ppe_data), .dio_bus(dio_bus));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    host_addr = hidden_reg_pkg::AUX_MODE_OFS;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    host_wr = 1'b0;
  endtask : wr

  task automatic settle(input logic cmd, input logic fast, output int cnt);
    @(posedge clk_sys);
    #1;
    xfer_cmd = cmd;
    fast_timing = fast;
    xfer_start = 1'b1;
    @(posedge clk_sys);
    #1;
    xfer_start = 1'b0;
    cnt = 0;
    while (settle_done !== 1'b1 && cnt < 200)
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
      if (cnt == 1)
        check({7'h0, settle_busy}, 8'h01);
    end
  endtask : settle

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    #200000;
    fails++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    check(dio_oe, 8'h00);
    check({7'h0, settle_busy}, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(rows[i].wdata);
      ist = rows[i].ist;
      pc.poll(got);
      check(got, rows[i].oe);
    end
    check(dio_out, 8'h00);
    host_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    host_rd = 1'b0;
    @(posedge clk_sys);
    #1;
    check(host_rdata, 8'h00);
    $display("table test done");
    wr(8'h20);
    settle(1'b0, 1'b0, n);
    check(8'(n), 8'h05);
    check({7'h0, settle_busy}, 8'h00);
    settle(1'b0, 1'b1, n);
    check(8'(n), 8'h02);
    settle(1'b1, 1'b0, n);
    check(8'(n), 8'h05);
    wr(8'h23);
    settle(1'b0, 1'b0, n);
    check(8'(n), 8'h0D);
    $display("settle test done");
    remote_cfg_mode = 1'b1;
    ist = 1'b1;
    pc.send(4'h4, 4'hA);
    pc.poll(got);
    check(got, 8'h00);
    pc.send(4'h8, 4'h0);
    pc.send(4'h4, 4'hA);
    pc.poll(got);
    check(got, 8'h04);
    pc.send(4'h1, 4'h0);
    pc.send(4'h4, 4'h8);
    pc.poll(got);
    check(got, 8'h04);
    pc.send(4'h8, 4'h0);
    pc.send(4'h2, 4'h0);
    pc.poll(got);
    check(got, 8'h00);
    $display("remote test done");
    remote_cfg_mode = 1'b0;
    wr(8'h69);
    @(posedge clk_sys);
    #1;
    chip_reset_cmd = 1'b1;
    @(posedge clk_sys);
    #1;
    chip_reset_cmd = 1'b0;
    pc.poll(got);
    check(got, 8'h00);
    settle(1'b0, 1'b0, n);
    check(8'(n), 8'h15);
    wr(8'h23);
    wr(8'h69);
    pon = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    pon = 1'b0;
    pc.poll(got);
    check(got, 8'h00);
    settle(1'b0, 1'b0, n);
    check(8'(n), 8'h15);
    wr(8'h25);
    $display("clear test done");
    finish_test();
  end
endmodule : hidden_register_loader_poll_config_test
